// ### design/rsf_pkg.sv
/*
  Package for the reset state and flag logic: reset causes, init kinds,
  the init cycle count and the reset values loaded into the core.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rsf_pkg;
  localparam int PC_W = 11;
  localparam int SP_W = 3;
  localparam int PORT_W = 8;
  localparam int INT_W = 8;
  localparam int TMR_W = 2;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic [SP_W-1:0] SP_RST = 3'h0;
  localparam logic [PORT_W-1:0] PORT_DIR_IN = 8'hff;
  localparam logic [INT_W-1:0] INT_EN_RST = 8'h00;
  localparam logic [TMR_W-1:0] TMR_ON_RST = 2'h0;
  // Cycles the init state lasts before execution is released.
  localparam logic [3:0] INIT_CYCLES = 4'h2;

  typedef enum logic [2:0] {
    RSF_CAUSE_NONE,
    RSF_CAUSE_POR,
    RSF_CAUSE_PIN,
    RSF_CAUSE_LOWV,
    RSF_CAUSE_WDOG
  } rsf_cause_t;

  typedef enum logic [1:0] {
    RSF_KIND_FULL,
    RSF_KIND_WARM,
    RSF_KIND_POR
  } rsf_kind_t;
endpackage

// ### design/rsf_cause_latch.sv
/*
  Captures the reset cause and the operating mode at each edge where take is high
  and a reset request stands, with power-on taking priority over everything else.
  Assumes request inputs are already synchronous to clk.
*/
`timescale 1ns/1ps
module rsf_cause_latch
  import rsf_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic por_req,
  input wire logic pin_req,
  input wire logic lowv_req,
  input wire logic wdog_req,
  input wire logic low_power,
  input wire logic take,
  output logic hit,
  output rsf_cause_t cause_q,
  output logic low_power_q
);
  rsf_cause_t cause_d;
  rsf_cause_t cur;
  logic low_power_d;

  // Priority encode the request lines; power-on beats all others.
  always_comb begin
    cur = RSF_CAUSE_NONE;
    if (por_req) begin
      cur = RSF_CAUSE_POR;
    end else if (pin_req) begin
      cur = RSF_CAUSE_PIN;
    end else if (lowv_req) begin
      cur = RSF_CAUSE_LOWV;
    end else if (wdog_req) begin
      cur = RSF_CAUSE_WDOG;
    end
    hit = (cur != RSF_CAUSE_NONE);
    cause_d = cause_q;
    low_power_d = low_power_q;
    if (take && hit) begin
      cause_d = cur;
      low_power_d = low_power;
    end
  end

  // The record stays until the next request so the sequencer can read it.
  always_ff @(posedge clk) begin
    if (srst) begin
      cause_q <= RSF_CAUSE_POR;
      low_power_q <= 1'b0;
    end else begin
      cause_q <= cause_d;
      low_power_q <= low_power_d;
    end
  end
endmodule

// ### design/rsf_reset_seq.sv
/*
  Reset state and flag sequencer. Records each reset cause and the mode the
  core was in, updates the time-out and power-down flags, drives the init
  strobes that load core state, and releases execution afterwards.
  The cause record sits in a small latch beside the sequencer. Its capture
  is always open, so a request that arrives during init replaces the record
  and restarts the sequence. Software flag events apply in every state but
  lose to any reset that starts its init in the same cycle.
  The init values are constants; the core picks from init_kind which of them
  to load, since a warm reset reloads only the program counter and stack pointer.
  Assumes reset request inputs are synchronous pulses or levels from logic
  on clk, and that the core holds its state while run_en is low.
*/
`timescale 1ns/1ps
module rsf_reset_seq
  import rsf_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic por_req,
  input wire logic external_reset_pin,
  input wire logic low_voltage_reset,
  input wire logic watchdog_timer,
  input wire logic low_power_mode,
  input wire logic powerdown_set,
  input wire logic flags_clear,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic run_en,
  output logic init_strobe,
  output rsf_kind_t init_kind,
  output logic [PC_W-1:0] pc_init,
  output logic [SP_W-1:0] sp_init,
  output logic [INT_W-1:0] int_en_init,
  output logic [TMR_W-1:0] tmr_on_init,
  output logic [PORT_W-1:0] port_dir_init,
  output logic wdog_clear,
  output logic wdog_run
);
  // Hold waits for the requests to drop, init pulses the strobes and counts, run lets the core execute.
  typedef enum logic [1:0] {
    RSF_ST_HOLD,
    RSF_ST_INIT,
    RSF_ST_RUN
  } rsf_state_t;

  rsf_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic to_q, to_d;
  logic pd_q, pd_d;
  logic run_q, run_d;
  logic strobe_q, strobe_d;
  rsf_kind_t kind_q, kind_d;
  logic wclr_q, wclr_d;
  logic wrun_q, wrun_d;
  logic hit;
  // Cause record from the latch, with the mode taken at the same edge.
  logic lp_q;
  rsf_cause_t cause_q;

  // Cause capture is open in every state so a request during init restarts it.
  rsf_cause_latch u_latch (
    .clk(clk),
    .srst(srst),
    .por_req(por_req),
    .pin_req(external_reset_pin),
    .lowv_req(low_voltage_reset),
    .wdog_req(watchdog_timer),
    .low_power(low_power_mode),
    .take(1'b1),
    .hit(hit),
    .cause_q(cause_q),
    .low_power_q(lp_q)
  );

  // Sequencer: hold while a request stands, init for a fixed count, then run.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    run_d = run_q;
    strobe_d = 1'b0;
    kind_d = kind_q;
    wclr_d = 1'b0;
    wrun_d = wrun_q;
    to_d = to_q;
    pd_d = pd_q;
    // Software-side events; a reset event below overrides them in the same cycle.
    // Set wins over clear when both software events fall in one cycle.
    if (flags_clear) begin
      to_d = 1'b0;
      pd_d = 1'b0;
    end
    if (powerdown_set) begin
      pd_d = 1'b1;
    end
    case (state_q)
      RSF_ST_HOLD: begin
        // Execution stays off while any request is still standing.
        run_d = 1'b0;
        if (!hit) begin
          state_d = RSF_ST_INIT;
          cnt_d = INIT_CYCLES;
          strobe_d = 1'b1;
          // Flags follow the recorded cause, overriding any software set or clear in this cycle.
          if (cause_q == RSF_CAUSE_POR) begin
            to_d = 1'b0;
            pd_d = 1'b0;
            kind_d = RSF_KIND_POR;
          end else if (cause_q == RSF_CAUSE_WDOG && lp_q) begin
            // A time-out in sleep is a warm reset: only the program counter and stack pointer reload.
            to_d = 1'b1;
            pd_d = 1'b1;
            kind_d = RSF_KIND_WARM;
          end else if (cause_q == RSF_CAUSE_WDOG) begin
            // A time-out while running marks only the time-out flag; a sleep pulse now is dropped.
            to_d = 1'b1;
            pd_d = pd_q;
            kind_d = RSF_KIND_FULL;
          end else begin
            // Pin and low-voltage resets keep both flags, whatever the mode was.
            to_d = to_q;
            pd_d = pd_q;
            kind_d = RSF_KIND_FULL;
          end
          // Warm reset leaves the watchdog and time bases running untouched.
          if (kind_d != RSF_KIND_WARM) begin
            wclr_d = 1'b1;
            wrun_d = 1'b0;
          end
        end
      end
      RSF_ST_INIT: begin
        // A new request abandons init; the latch has already recorded the new cause.
        // The count runs from INIT_CYCLES down to one, so init lasts that many cycles.
        if (hit) begin
          state_d = RSF_ST_HOLD;
        end else if (cnt_q == 4'h1) begin
          state_d = RSF_ST_RUN;
          run_d = 1'b1;
          wrun_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      RSF_ST_RUN: begin
        // Any request stops execution at the next edge.
        if (hit) begin
          state_d = RSF_ST_HOLD;
          run_d = 1'b0;
        end
      end
      default: begin
        state_d = RSF_ST_HOLD;
      end
    endcase
  end

  // Power-on state: held, flags clear, watchdog stopped until execution is released.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= RSF_ST_HOLD;
      cnt_q <= 4'h0;
      run_q <= 1'b0;
      strobe_q <= 1'b0;
      kind_q <= RSF_KIND_POR;
      wclr_q <= 1'b0;
      wrun_q <= 1'b0;
      to_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      strobe_q <= strobe_d;
      kind_q <= kind_d;
      wclr_q <= wclr_d;
      wrun_q <= wrun_d;
      to_q <= to_d;
      pd_q <= pd_d;
    end
  end

  // Init values are constant; consumers apply them only for the kinds that need them.
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_init <= PC_RST;
      sp_init <= SP_RST;
      int_en_init <= INT_EN_RST;
      tmr_on_init <= TMR_ON_RST;
      port_dir_init <= PORT_DIR_IN;
    end else begin
      pc_init <= PC_RST;
      sp_init <= SP_RST;
      int_en_init <= INT_EN_RST;
      tmr_on_init <= TMR_ON_RST;
      port_dir_init <= PORT_DIR_IN;
    end
  end

  // Every output leaves straight from its register, so no glitch reaches the core.
  assign timeout_flag = to_q;
  assign powerdown_flag = pd_q;
  assign run_en = run_q;
  assign init_strobe = strobe_q;
  assign init_kind = kind_q;
  assign wdog_clear = wclr_q;
  assign wdog_run = wrun_q;
endmodule

// ### test/rsf_seq_properties.sv
/*
  Checker for the reset state and flag sequencer outputs.
  Assumes it is bound to rsf_reset_seq and sees only its ports.
*/
`timescale 1ns/1ps
module rsf_seq_properties
  import rsf_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  input wire logic run_en,
  input wire logic init_strobe,
  input wire rsf_kind_t init_kind,
  input wire logic [PC_W-1:0] pc_init,
  input wire logic [SP_W-1:0] sp_init,
  input wire logic [INT_W-1:0] int_en_init,
  input wire logic [TMR_W-1:0] tmr_on_init,
  input wire logic [PORT_W-1:0] port_dir_init,
  input wire logic wdog_clear,
  input wire logic wdog_run
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Release must follow an init pulse, and the flags must match the kind it loads.
  run_after_init_a: assert property ($rose(run_en) |-> $past(init_strobe, 2))
    else $error("run without init");
  warm_flags_a: assert property (
    init_strobe && init_kind == RSF_KIND_WARM |-> timeout_flag && powerdown_flag)
    else $error("warm flags wrong");
  por_flags_a: assert property (
    init_strobe && init_kind == RSF_KIND_POR |-> !timeout_flag && !powerdown_flag)
    else $error("por flags wrong");
  full_pd_a: assert property (
    init_strobe && init_kind == RSF_KIND_FULL |-> powerdown_flag == $past(powerdown_flag))
    else $error("pd changed");
  to_rise_a: assert property ($rose(timeout_flag) |-> init_strobe) else $error("stray timeout");
  wdog_clear_kind_a: assert property (init_strobe |-> wdog_clear == (init_kind != RSF_KIND_WARM))
    else $error("watchdog clear wrong");
  pc_sp_zero_a: assert property (init_strobe |-> pc_init == PC_RST && sp_init == SP_RST)
    else $error("pc sp wrong");
  cold_defaults_a: assert property (
    init_strobe && init_kind != RSF_KIND_WARM |-> int_en_init == INT_EN_RST
    && tmr_on_init == TMR_ON_RST && port_dir_init == PORT_DIR_IN) else $error("defaults wrong");
  wdog_counts_a: assert property ($rose(run_en) |-> wdog_run) else $error("watchdog idle");
  // Each init kind is seen at least once.
  warm_c: cover property (init_strobe && init_kind == RSF_KIND_WARM);
  full_c: cover property (init_strobe && init_kind == RSF_KIND_FULL);
  por_c: cover property (init_strobe && init_kind == RSF_KIND_POR);
endmodule

bind rsf_reset_seq rsf_seq_properties rsf_seq_properties_i (.clk(clk), .srst(srst), .timeout_flag(timeout_flag),
  .powerdown_flag(powerdown_flag), .run_en(run_en), .init_strobe(init_strobe), .init_kind(init_kind),
  .pc_init(pc_init), .sp_init(sp_init), .int_en_init(int_en_init), .tmr_on_init(tmr_on_init),
  .port_dir_init(port_dir_init), .wdog_clear(wdog_clear), .wdog_run(wdog_run));

// ### test/testbench.sv
/*
  Self-checking bench for the reset state and flag sequencer.
  Assumes the checker file is compiled with it; no partner model is used.
*/
`timescale 1ns/1ps
module testbench;
  import rsf_pkg::*;
  logic clk = 0, srst = 1, lp = 0, pd_set = 0, f_clr = 0;
  logic [3:0] rq = 4'h0;
  logic to_f, pd_f, run_en, strb, wclr, wrun;
  rsf_kind_t kind;
  logic [PC_W-1:0] pc;
  logic [SP_W-1:0] sp;
  logic [INT_W-1:0] ien;
  logic [TMR_W-1:0] tmr;
  logic [PORT_W-1:0] pdir;
  int err_count = 0, checks = 0;
  logic to_e = 0, pd_e = 0;
  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;
  rsf_reset_seq rsf_reset_seq_i (.clk(clk), .srst(srst), .por_req(rq[3]), .external_reset_pin(rq[2]),
    .low_voltage_reset(rq[1]), .watchdog_timer(rq[0]), .low_power_mode(lp), .powerdown_set(pd_set),
    .flags_clear(f_clr), .timeout_flag(to_f), .powerdown_flag(pd_f), .run_en(run_en), .init_strobe(strb),
    .init_kind(kind), .pc_init(pc), .sp_init(sp), .int_en_init(ien), .tmr_on_init(tmr),
    .port_dir_init(pdir), .wdog_clear(wclr), .wdog_run(wrun));
  // Compares with case equality so an unknown never matches.
  task automatic chk(string n, logic [10:0] seen, logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Holds one request for a single edge; bit 3 is power-on, bit 0 the watchdog.
  task automatic req(int s, logic l);
    @(posedge clk);
    rq <= 4'h8 >> s;
    lp <= l;
    @(posedge clk);
    rq <= 4'h0;
  endtask
  // Software pulse on the flags, then a look at the power-down flag.
  task automatic pulse(logic c);
    @(posedge clk);
    if (c) f_clr <= 1;
    else pd_set <= 1;
    @(posedge clk);
    f_clr <= 0;
    pd_set <= 0;
    @(negedge clk);
    chk("pd_pulse", pd_f, pd_e);
  endtask
  // Waits a bounded time for the init pulse, then judges the loaded state and the release.
  task automatic wait_init(rsf_kind_t k);
    int n;
    n = 0;
    while (strb !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("strobe", strb, 1);
    chk("kind", kind, k);
    chk("timeout", to_f, to_e);
    chk("powerdown", pd_f, pd_e);
    chk("run_held", run_en, 0);
    chk("pc", pc, PC_RST);
    chk("sp", sp, SP_RST);
    chk("wdog_clear", wclr, k != RSF_KIND_WARM);
    if (k != RSF_KIND_WARM) begin
      chk("int_en", ien, INT_EN_RST);
      chk("tmr_on", tmr, TMR_ON_RST);
      chk("port_dir", pdir, PORT_DIR_IN);
    end
    repeat (2) @(negedge clk);
    chk("run", run_en, 1);
    chk("wdog_run", wrun, 1);
  endtask
  // A watchdog reset in sleep keeps state and leaves both flags set.
  task automatic t_wdt_sleep();
    pd_e = 1;
    pulse(0);
    to_e = 1;
    req(3, 1);
    wait_init(RSF_KIND_WARM);
  endtask
  // A watchdog reset while running sets only the time-out flag.
  task automatic t_wdt_run();
    to_e = 0;
    pd_e = 0;
    pulse(1);
    to_e = 1;
    req(3, 0);
    wait_init(RSF_KIND_FULL);
  endtask
  // Pin and low-voltage resets leave both flags as they were, in either mode.
  task automatic t_pin_lvr();
    pd_e = 1;
    pulse(0);
    for (int s = 1; s < 3; s++) begin
      req(s, 0);
      wait_init(RSF_KIND_FULL);
      req(s, 1);
      wait_init(RSF_KIND_FULL);
    end
  endtask
  // A running time-out ignores a sleep pulse on its init edge; a pin reset during init restarts it.
  task automatic t_overlap();
    to_e = 1;
    pd_e = 0;
    pulse(1);
    @(posedge clk);
    rq <= 4'h1;
    lp <= 0;
    @(posedge clk);
    rq <= 4'h0;
    pd_set <= 1;
    @(posedge clk);
    pd_set <= 0;
    rq <= 4'h4;
    @(posedge clk);
    rq <= 4'h0;
    @(negedge clk);
    chk("pd_kept", pd_f, 0);
    chk("to_set", to_f, 1);
    wait_init(RSF_KIND_FULL);
    pd_e = 1;
    pulse(0);
  endtask
  // A power-on request with both flags set clears them.
  task automatic t_por();
    to_e = 0;
    pd_e = 0;
    req(0, 0);
    wait_init(RSF_KIND_POR);
  endtask
  // Main sequence: reset acts as power-on, then each reset cause in turn.
  initial begin
    repeat (16) @(posedge clk);
    srst <= 0;
    wait_init(RSF_KIND_POR);
    t_wdt_sleep();
    t_wdt_run();
    t_pin_lvr();
    t_overlap();
    t_por();
    summarize();
  end
  // The run needs about seventy cycles against a limit of a thousand, so this only trips on a hang.
  initial begin
    #25000;
    err_count++;
    summarize();
  end
endmodule
